//--- hw/tve_pkg.sv
// Constants, types and limit tables for the thermo/voltage value encoder.
// Assumes one 250 MHz clock and a front end that posts scaled results.
package tve_pkg;

	// ==========================================================
	// Sizes and carriers
	localparam int CH_N = 4;
	localparam int RAW_W = 20;
	localparam int OVF_BIT_DEF = 0;

	typedef logic [15:0] word_t;
	typedef logic signed [RAW_W-1:0] raw_t;
	typedef logic [CH_N-1:0][15:0] words_t;

	typedef enum logic [2:0] {
		TYPE_N = 3'b000,
		TYPE_RS = 3'b001,
		TYPE_T = 3'b010,
		TYPE_MV = 3'b011
	} sensor_e;

	typedef enum logic [1:0] {
		BAND_NOM = 2'b00,
		BAND_RANGE = 2'b01,
		BAND_OVF = 2'b10,
		BAND_UNF = 2'b11
	} band_e;

	// Thermo types in 0.1 degree units, millivolt input in microvolts
	typedef struct packed {
		logic [CH_N-1:0] valid;
		logic [CH_N-1:0] wire_break;
		logic [CH_N-1:0][RAW_W-1:0] data;
	} conv_s;

	typedef struct packed {
		logic [31:0] cfg;
		logic param_set;
		logic [CH_N-1:0] first_done;
		logic [CH_N-1:0] oc_diag;
		logic [2*CH_N-1:0] bands;
		words_t words;
		logic sup1;
		logic sup2;
	} state_s;

	// ==========================================================
	// Output codes
	localparam word_t WORD_OVF = 16'h7FFF;
	localparam word_t WORD_UNF = 16'h8000;

	// ==========================================================
	// Limit tables, indexed by sensor type
	localparam raw_t OVF_LIM [4] = '{20'sh03C8C, 20'sh04EDE, 20'sh01518,
		20'sh16F77};
	localparam raw_t UNF_LIM [4] = '{20'shFF574, 20'shFF95C, 20'shFF574,
		20'shE9086};
	localparam raw_t NOM_HI [4] = '{20'sh032C8, 20'sh0451A, 20'sh00FA0,
		20'sh13880};
	localparam raw_t NOM_LO [4] = '{20'shFF574, 20'shFFE0C, 20'shFF574,
		20'shEC780};
	localparam word_t LEG_HI [4] = '{16'h3C8D, 16'h4EDF, 16'h1519,
		16'h7F00};
	localparam word_t LEG_LO [4] = '{16'hF573, 16'hF95B, 16'hF573,
		16'h80FF};

	// Millivolt scaling: code = uV * 3456 / 10000, rounded
	localparam logic signed [33:0] MV_NUM = 34'sh00000D80;
	localparam logic signed [33:0] MV_DEN = 34'sh00002710;
	localparam logic signed [33:0] MV_HALF = 34'sh00001388;

	// ==========================================================
	// Register map and fields
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_BAND = 8'h08;
	localparam logic [7:0] ADDR_DATA0 = 8'h10;
	localparam logic [7:0] ADDR_DATA3 = 8'h1C;
	localparam int CFG_FMT_BIT = 0;
	localparam int CFG_OC_BIT = 1;
	localparam int CFG_TYPE_LSB = 4;
	localparam int CFG_TYPE_STRIDE = 4;
	localparam int STAT_PSET_BIT = 4;
	localparam int STAT_SUP_BIT = 5;
	localparam int STAT_OC_LSB = 8;
	localparam logic [31:0] CFG_RST = 32'h00000000;

endpackage

//--- hw/tve_range_encoder.sv
// One channel's range classifier and output word encoder.
// Assumes the caller registers the word; purely combinational here.
`timescale 1ns/10ps
module tve_range_encoder #(
	parameter int OVF_BIT = tve_pkg::OVF_BIT_DEF
) (
	input wire tve_pkg::sensor_e sensor,
	input wire tve_pkg::raw_t raw,
	input wire logic legacy,
	output tve_pkg::word_t word,
	output tve_pkg::band_e band,
	output logic type_ok
);
	import tve_pkg::*;

	logic signed [33:0] prod;
	logic signed [33:0] rnd;
	word_t value;
	word_t flag;
	int idx;

	// ==========================================================
	// Classify and encode
	always_comb begin
		type_ok = sensor inside {TYPE_N, TYPE_RS, TYPE_T, TYPE_MV};
		idx = type_ok ? int'(sensor) : 0; // see RULE20
		prod = 34'(raw) * MV_NUM;
		rnd = (prod + ((prod < 0) ? -MV_HALF : MV_HALF)) / MV_DEN; // see RULE6
		flag = word_t'(16'h0001 << OVF_BIT); // see RULE19
		value = (sensor == TYPE_MV) ? rnd[15:0] : raw[15:0]; // see RULE18
		if (raw > OVF_LIM[idx]) begin // see RULE1 RULE3 RULE5 RULE7
			band = BAND_OVF;
			word = legacy ? (LEG_HI[idx] | flag) : WORD_OVF; // see RULE13 RULE14
		end else if (raw < UNF_LIM[idx]) begin // see RULE2 RULE4 RULE5 RULE8
			band = BAND_UNF;
			word = legacy ? (LEG_LO[idx] | flag) : WORD_UNF; // see RULE13 RULE15
		end else if (raw > NOM_HI[idx] || raw < NOM_LO[idx]) begin
			band = BAND_RANGE;
			word = value; // see RULE12
		end else begin
			band = BAND_NOM;
			word = value; // see RULE12
		end
	end

endmodule

//--- hw/thermo_voltage_value_encoder.sv
// Four-channel encoder of thermocouple and millivolt results into
// 16-bit input words, with an APB register slave.
// Assumes conversion results arrive on pclk; supply pin is asynchronous.
`timescale 1ns/10ps

// Functional notes
// RULE1 - Type N: nominal to 13000, overrange to 15500, 7FFF above 1550.0 degrees.
// RULE2 - Type N: 8000 below -270.0 degrees, no underrange band.
// RULE3 - Types R,S: nominal to 17690, overrange to 20190, 7FFF above.
// RULE4 - Types R,S: nominal to -500, underrange to -1700, 8000 below.
// RULE5 - Type T: nominal -2700..4000, overrange to 5400, flow codes outside.
// RULE6 - Millivolt range maps +-80 mV linearly onto +-27648.
// RULE7 - Millivolt overrange 27649..32511, 7FFF above 94.071 mV.
// RULE8 - Millivolt underrange -27649..-32512, 8000 below -94.074 mV.
// RULE9 - 7FFF after start or new parameters until first conversion.
// RULE10 - Missing load supply forces 7FFF on every word.
// RULE11 - Live values continue regardless of controller run or stop.
// RULE12 - Nominal and over/underrange values pass through unchanged.
// RULE13 - Primary format saturates overflow to 7FFF, underflow to 8000.
// RULE14 - Legacy overflow gives upper limit plus one with flag bit.
// RULE15 - Legacy underflow gives lower limit minus one with flag bit.
// RULE16 - No or invalid parameters give 7FFF in both formats.
// RULE17 - Open-circuit check gives 7FFF and raises a diagnostic.
// RULE18 - Sign in bit 15, two's complement.
// RULE19 - Legacy flag bit position is a parameter, default bit 0.
// RULE20 - Limits from constant tables by type; word one cycle later.
module thermo_voltage_value_encoder #(
	parameter int OVF_BIT = tve_pkg::OVF_BIT_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tve_pkg::conv_s conv_i,
	input wire logic supply_ok,
	output tve_pkg::words_t in_words
);
	import tve_pkg::*;

	state_s st_q;
	state_s st_d;
	logic wr;
	logic cfg_wr;
	logic acc;
	logic mapped;
	logic [CH_N-1:0] oc_clr;
	logic [CH_N-1:0] oc_set;
	logic [CH_N-1:0] type_ok;
	logic legacy;
	logic oc_en;
	word_t enc_word [CH_N];
	band_e enc_band [CH_N];
	sensor_e ch_type [CH_N];

	// ==========================================================
	// Configuration fields
	assign legacy = st_q.cfg[CFG_FMT_BIT];
	assign oc_en = st_q.cfg[CFG_OC_BIT];

	// ==========================================================
	// Per-channel encoders
	for (genvar g = 0; g < CH_N; g++) begin : g_ch
		assign ch_type[g] = sensor_e'(st_q.cfg[CFG_TYPE_LSB +
			g * CFG_TYPE_STRIDE +: 3]);
		tve_range_encoder #(
			.OVF_BIT(OVF_BIT)
		) u_enc (
			.sensor(ch_type[g]),
			.raw(raw_t'(conv_i.data[g])),
			.legacy(legacy),
			.word(enc_word[g]),
			.band(enc_band[g]),
			.type_ok(type_ok[g])
		);
	end

	// ==========================================================
	// APB decode
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign cfg_wr = wr && (paddr == ADDR_CFG);
	assign mapped = (paddr[1:0] == 2'b00) && ((paddr <= ADDR_BAND) ||
		((paddr >= ADDR_DATA0) && (paddr <= ADDR_DATA3)));
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign oc_clr = (wr && (paddr == ADDR_STAT)) ?
		pwdata[STAT_OC_LSB +: CH_N] : '0;

	always_comb begin
		prdata = 32'h00000000;
		case (paddr)
			ADDR_CFG: begin
				prdata = st_q.cfg;
			end
			ADDR_STAT: begin
				prdata[CH_N-1:0] = st_q.first_done;
				prdata[STAT_PSET_BIT] = st_q.param_set;
				prdata[STAT_SUP_BIT] = st_q.sup2;
				prdata[STAT_OC_LSB +: CH_N] = st_q.oc_diag;
			end
			ADDR_BAND: begin
				prdata[2*CH_N-1:0] = st_q.bands;
			end
			default: begin
				if (paddr >= ADDR_DATA0 && paddr <= ADDR_DATA3 &&
					paddr[1:0] == 2'b00) begin
					prdata[15:0] = st_q.words[paddr[3:2]];
				end
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.sup1 = supply_ok;
		st_d.sup2 = st_q.sup1;
		oc_set = '0;
		if (cfg_wr) begin
			st_d.cfg = pwdata;
			st_d.param_set = 1'b1;
			st_d.first_done = '0; // see RULE9
		end
		for (int i = 0; i < CH_N; i++) begin
			if (conv_i.valid[i] && !cfg_wr) begin
				st_d.first_done[i] = 1'b1;
				st_d.bands[2*i +: 2] = enc_band[i];
				oc_set[i] = oc_en && conv_i.wire_break[i];
			end
		end
		// Set wins over a software clear in the same cycle
		st_d.oc_diag = (st_q.oc_diag & ~oc_clr) | oc_set; // see RULE17
		for (int i = 0; i < CH_N; i++) begin
			if (!st_q.sup2) begin
				st_d.words[i] = WORD_OVF; // see RULE10
			end else if (!st_d.param_set || !type_ok[i]) begin
				st_d.words[i] = WORD_OVF; // see RULE16
			end else if (!st_d.first_done[i]) begin
				st_d.words[i] = WORD_OVF; // see RULE9
			end else if (oc_set[i]) begin
				st_d.words[i] = WORD_OVF; // see RULE17
			end else if (conv_i.valid[i]) begin
				st_d.words[i] = enc_word[i]; // see RULE11 RULE20
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q.cfg <= CFG_RST;
			st_q.param_set <= 1'b0;
			st_q.first_done <= '0;
			st_q.oc_diag <= '0;
			st_q.bands <= '0;
			st_q.words <= {CH_N{WORD_OVF}};
			st_q.sup1 <= 1'b0;
			st_q.sup2 <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign in_words = st_q.words;

	// ==========================================================
	// Assertions on channel 0, except supply checks on channels 0, 1 and 3, the restart check on channel 2 and c_open on channel 1
	raw_t d0;
	logic live0;
	sensor_e ty0;
	assign d0 = raw_t'(conv_i.data[0]);
	assign ty0 = ch_type[0];
	assign live0 = conv_i.valid[0] && !conv_i.wire_break[0] &&
		st_q.sup2 && st_q.param_set && !cfg_wr;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_supply_off;
		!st_q.sup2 |=> in_words[0] == WORD_OVF && in_words[3] == WORD_OVF;
	endproperty
	a_supply_off: assert property (p_supply_off) // see RULE10
		else $error("word not 7FFF with supply missing");

	property p_pin_to_force;
		$fell(supply_ok) ##2 1'b1 |=> in_words[1] == WORD_OVF;
	endproperty
	a_pin_to_force: assert property (p_pin_to_force) // see RULE10
		else $error("supply loss not forcing within three cycles");

	property p_no_param;
		!st_q.param_set |=> in_words[0] == WORD_OVF;
	endproperty
	a_no_param: assert property (p_no_param) // see RULE16
		else $error("word not 7FFF before parameters");

	property p_restart;
		cfg_wr ##1 !conv_i.valid[2] [*2] |=> in_words[2] == WORD_OVF;
	endproperty
	a_restart: assert property (p_restart) // see RULE9
		else $error("word not 7FFF after new parameters");

	property p_n_ovf;
		live0 && ty0 == TYPE_N && !legacy && d0 > OVF_LIM[0]
			|=> in_words[0] == WORD_OVF;
	endproperty
	a_n_ovf: assert property (p_n_ovf) // see RULE1
		else $error("type N overflow not 7FFF");

	property p_t_unf;
		live0 && ty0 == TYPE_T && !legacy && d0 < UNF_LIM[2]
			|=> in_words[0] == WORD_UNF;
	endproperty
	a_t_unf: assert property (p_t_unf) // see RULE5
		else $error("type T underflow not 8000");

	property p_rs_under;
		live0 && ty0 == TYPE_RS && d0 >= UNF_LIM[1] && d0 < NOM_LO[1]
			|=> in_words[0] == $past(d0[15:0]) &&
			st_q.bands[1:0] == BAND_RANGE;
	endproperty
	a_rs_under: assert property (p_rs_under) // see RULE4
		else $error("R/S underrange not passed through");

	property p_mv_scale;
		live0 && ty0 == TYPE_MV && d0 == 20'sh0EA60
			|=> in_words[0] == 16'h5100;
	endproperty
	a_mv_scale: assert property (p_mv_scale) // see RULE6
		else $error("60 mV not mapped to 20736");

	property p_leg_ovf;
		live0 && ty0 == TYPE_N && legacy && d0 > OVF_LIM[0]
			|=> in_words[0] == (LEG_HI[0] | word_t'(16'h0001 << OVF_BIT));
	endproperty
	a_leg_ovf: assert property (p_leg_ovf) // see RULE14
		else $error("legacy overflow code wrong");

	property p_leg_unf;
		live0 && ty0 == TYPE_MV && legacy && d0 < UNF_LIM[3]
			|=> in_words[0] == (LEG_LO[3] | word_t'(16'h0001 << OVF_BIT));
	endproperty
	a_leg_unf: assert property (p_leg_unf) // see RULE15
		else $error("legacy underflow code wrong");

	property p_open;
		conv_i.valid[0] && conv_i.wire_break[0] && oc_en && !cfg_wr
			|=> in_words[0] == WORD_OVF && st_q.oc_diag[0];
	endproperty
	a_open: assert property (p_open) // see RULE17
		else $error("open circuit not flagged");

	property p_hold;
		st_q.sup2 && st_q.first_done[0] && !conv_i.valid[0] &&
			!cfg_wr && $stable(st_q.sup2)
			|=> $stable(in_words[0]);
	endproperty
	a_hold: assert property (p_hold) // see RULE11
		else $error("word changed without a conversion");

	property p_n_unf;
		live0 && ty0 == TYPE_N && !legacy && d0 < UNF_LIM[0]
			|=> in_words[0] == WORD_UNF;
	endproperty
	a_n_unf: assert property (p_n_unf) // see RULE2
		else $error("type N underflow not 8000");

	property p_n_pass;
		live0 && ty0 == TYPE_N && d0 <= OVF_LIM[0] &&
			d0 >= UNF_LIM[0] |=> in_words[0] == $past(d0[15:0]);
	endproperty
	a_n_pass: assert property (p_n_pass) // see RULE12
		else $error("type N in-range value not passed through");

	property p_rs_ovf;
		live0 && ty0 == TYPE_RS && !legacy && d0 > OVF_LIM[1]
			|=> in_words[0] == WORD_OVF;
	endproperty
	a_rs_ovf: assert property (p_rs_ovf) // see RULE3
		else $error("R/S overflow not 7FFF");

	property p_t_ovf;
		live0 && ty0 == TYPE_T && !legacy && d0 > OVF_LIM[2]
			|=> in_words[0] == WORD_OVF;
	endproperty
	a_t_ovf: assert property (p_t_ovf) // see RULE5
		else $error("type T overflow not 7FFF");

	property p_mv_ovf;
		live0 && ty0 == TYPE_MV && !legacy && d0 > OVF_LIM[3]
			|=> in_words[0] == WORD_OVF;
	endproperty
	a_mv_ovf: assert property (p_mv_ovf) // see RULE7
		else $error("millivolt overflow not 7FFF");

	property p_mv_unf;
		live0 && ty0 == TYPE_MV && !legacy && d0 < UNF_LIM[3]
			|=> in_words[0] == WORD_UNF;
	endproperty
	a_mv_unf: assert property (p_mv_unf) // see RULE8
		else $error("millivolt underflow not 8000");

	property p_mv_neg;
		live0 && ty0 == TYPE_MV && d0 == 20'shF15A0
			|=> in_words[0] == 16'hAF00;
	endproperty
	a_mv_neg: assert property (p_mv_neg) // see RULE18
		else $error("-60 mV not mapped to -20736");

	property p_band_ovf;
		live0 && ty0 == TYPE_N && d0 > OVF_LIM[0]
			|=> st_q.bands[1:0] == BAND_OVF;
	endproperty
	a_band_ovf: assert property (p_band_ovf) // see RULE20
		else $error("overflow band not recorded one cycle later");

	property p_bad_type;
		st_q.cfg[CFG_TYPE_LSB + 2] |=> in_words[0] == WORD_OVF;
	endproperty
	a_bad_type: assert property (p_bad_type) // see RULE16
		else $error("word not 7FFF with invalid type");

	property p_wait_first;
		!st_q.first_done[0] && !conv_i.valid[0]
			|=> in_words[0] == WORD_OVF;
	endproperty
	a_wait_first: assert property (p_wait_first) // see RULE9
		else $error("word not 7FFF before first conversion");

	c_nominal: cover property (live0 ##1 st_q.bands[1:0] == BAND_NOM);
	c_overflow: cover property (live0 ##1 st_q.bands[1:0] == BAND_OVF);
	c_underflow: cover property (live0 ##1 st_q.bands[1:0] == BAND_UNF);
	c_open: cover property (oc_set[1] ##[1:20] oc_clr[1]);
	c_legacy: cover property (live0 && legacy && d0 > OVF_LIM[0]);

endmodule

//--- testbench/tve_front_model.sv
// Front-end model posting one scaled result per request.
// Assumes requests come from the bench just after pclk edges.
`timescale 1ns/10ps
module tve_front_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic [1:0] req_ch,
	input wire tve_pkg::raw_t req_data,
	input wire logic req_brk,
	output tve_pkg::conv_s conv
);
	import tve_pkg::*;
	// ==========================================================
	// Posting; lines toggle outside valid cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv <= '0;
		end else begin
			conv.valid <= req ? CH_N'(1) << req_ch : '0;
			conv.wire_break <= ~conv.wire_break;
			conv.data <= ~conv.data;
			if (req) begin
				conv.wire_break[req_ch] <= req_brk;
				conv.data[req_ch] <= req_data;
			end
		end
	end
endmodule

//--- testbench/thermo_voltage_value_encoder_tb_top.sv
// Self-checking bench of the value encoder.
// Assumes the front-end model and an APB master driven here.
`timescale 1ns/10ps
module thermo_voltage_value_encoder_tb_top;
	import tve_pkg::*;
	localparam logic [31:0] TYPES = 32'h00032100;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err, supply_ok, req, req_brk;
	logic [1:0] req_ch;
	raw_t req_data;
	conv_s conv;
	words_t in_words;
	int failures, num_checks, cycles;

	thermo_voltage_value_encoder dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_i(conv), .supply_ok(supply_ok),
		.in_words(in_words));
	tve_front_model fe (.pclk(pclk), .presetn(presetn), .req(req),
		.req_ch(req_ch), .req_data(req_data), .req_brk(req_brk),
		.conv(conv));

	// ==========================================================
	// Clock, timeout and shared tasks
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	task print_verdict;
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task enc(input int ch, input int v, input logic [15:0] exp,
		input logic b = 1'b0);
		@(posedge pclk);
		req <= 1'b1;
		req_ch <= ch[1:0];
		req_data <= raw_t'(v);
		req_brk <= b;
		@(posedge pclk);
		req <= 1'b0;
		@(posedge pclk);
		#1;
		chk(in_words[ch], exp);
	endtask

	task set_cfg(input logic [31:0] c);
		apb(1'b1, ADDR_CFG, c);
		#1;
		for (int i = 0; i < CH_N; i++)
			chk(in_words[i], WORD_OVF);
	endtask

	// ==========================================================
	// Scenarios
	task t_no_param;
		enc(0, 100, WORD_OVF);
		apb(1'b0, ADDR_STAT, 32'h00000000);
		chk(rd[STAT_PSET_BIT], 1'b0);
	endtask

	task t_primary;
		set_cfg(TYPES);
		enc(0, 15500, 16'h3C8C);
		enc(0, 15501, WORD_OVF);
		enc(0, -2700, 16'hF574);
		enc(0, -2701, WORD_UNF);
		enc(1, 20190, 16'h4EDE);
		enc(1, 20191, WORD_OVF);
		enc(1, -1700, 16'hF95C);
		enc(1, -1701, WORD_UNF);
		enc(2, 5400, 16'h1518);
		enc(2, 5401, WORD_OVF);
		enc(2, -2701, WORD_UNF);
		enc(3, 60000, 16'h5100);
		enc(3, -80000, 16'h9400);
		enc(3, 94071, 16'h7EFF);
		enc(3, 94072, WORD_OVF);
		enc(3, -94074, 16'h8100);
		enc(3, -94075, WORD_UNF);
	endtask

	task t_legacy;
		set_cfg(TYPES | 32'h00000001);
		enc(0, 15501, 16'h3C8D);
		enc(1, -1701, 16'hF95B);
		enc(2, -2701, 16'hF573);
		enc(3, 94072, 16'h7F01);
		enc(3, -94075, 16'h80FF);
		enc(1, 17691, 16'h451B);
	endtask

	task t_supply;
		@(posedge pclk);
		supply_ok <= 1'b0;
		repeat (4) @(posedge pclk);
		#1;
		for (int i = 0; i < CH_N; i++)
			chk(in_words[i], WORD_OVF);
		apb(1'b0, ADDR_STAT, 32'h00000000);
		chk(rd[STAT_SUP_BIT], 1'b0);
		@(posedge pclk);
		supply_ok <= 1'b1;
		repeat (4) @(posedge pclk);
		enc(1, -500, 16'hFE0C);
	endtask

	task t_open;
		set_cfg(TYPES | 32'h00000002);
		enc(1, 100, WORD_OVF, 1'b1);
		apb(1'b0, ADDR_STAT, 32'h00000000);
		chk(rd[STAT_OC_LSB+1], 1'b1);
		apb(1'b1, ADDR_STAT, 32'h00000200);
		apb(1'b0, ADDR_STAT, 32'h00000000);
		chk(rd[STAT_OC_LSB+1], 1'b0);
	endtask

	task t_ch0;
		set_cfg(32'h00000020);
		enc(0, -2701, WORD_UNF);
		enc(0, 5401, WORD_OVF);
		set_cfg(32'h00000010);
		enc(0, 20191, WORD_OVF);
		enc(0, -1000, 16'hFC18);
		apb(1'b0, ADDR_BAND, 32'h00000000);
		chk(rd[1:0], 2'b01);
		set_cfg(32'h00000030);
		enc(0, 60000, 16'h5100);
		enc(0, -60000, 16'hAF00);
		enc(0, 94072, WORD_OVF);
		enc(0, -94075, WORD_UNF);
		set_cfg(32'h00000031);
		enc(0, -94075, 16'h80FF);
		enc(0, 94072, 16'h7F01);
		set_cfg(32'h00000002);
		enc(0, 100, WORD_OVF, 1'b1);
		apb(1'b0, ADDR_STAT, 32'h00000000);
		chk(rd[STAT_OC_LSB], 1'b1);
	endtask

	task t_invalid_bus;
		set_cfg(32'h00032140);
		enc(0, 100, WORD_OVF);
		enc(2, 4000, 16'h0FA0);
		apb(1'b0, 8'h18, 32'h00000000);
		chk(rd, 32'h00000FA0);
		chk(err, 1'b0);
		apb(1'b0, 8'h0C, 32'h00000000);
		chk(err, 1'b1);
		chk(rd, 32'h00000000);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, req, req_brk} = '0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		req_ch = 2'h0;
		req_data = '0;
		supply_ok = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk(in_words[0], WORD_OVF);
		t_no_param();
		t_primary();
		t_legacy();
		t_supply();
		t_open();
		t_ch0();
		t_invalid_bus();
		print_verdict();
	end
endmodule
